// ===== hw/amdc_core.sv
// Modulation depth calibration controller and driver level select
`timescale 1ns/1ps
`default_nettype none
module amdc_core
	import amdc_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [7:0]       am_depth_control,
	input  wire logic [7:0]       normal_level,
	input  wire logic [7:0]       am_modulated_level,
	input  wire logic             am_vs_ook_select,
	input  wire logic             cal_cmd,
	input  wire logic             modulate,
	output logic                  adc_start,
	input  wire logic             adc_done,
	input  wire logic [7:0]       adc_value,
	output logic [7:0]            adc_result,
	output logic [7:0]            am_depth_display,
	output logic                  tx_on,
	output logic [7:0]            antenna_driver_out_a,
	output logic [7:0]            antenna_driver_out_b,
	output logic                  cal_busy
);
	// ==========================================================
	// Calibration sequencer
	amdc_state_t       st_r, st_nxt;
	logic [7:0]        ref_r, ref_nxt;
	logic [7:0]        tgt_r, tgt_nxt;
	logic [7:0]        trial_r, trial_nxt;
	logic [7:0]        bit_r, bit_nxt;
	logic [7:0]        disp_r, disp_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [RATIO_W-1:0] ratio;
	logic [6:0]        den;
	logic [14:0]       quo;
	logic              auto_sel;

	assign ratio    = am_depth_control[RATIO_HI:RATIO_LO];
	assign auto_sel = ~am_depth_control[SEL_BIT];
	// divide by 1.ratio; zero ratio keeps reference
	assign den = {1'b1, ratio};
	assign quo = {ref_r, {RATIO_W{1'b0}}} / {8'h00, den};

	always_comb begin
		st_nxt    = st_r;
		ref_nxt   = ref_r;
		tgt_nxt   = tgt_r;
		trial_nxt = trial_r;
		bit_nxt   = bit_r;
		disp_nxt  = disp_r;
		cnt_nxt   = cnt_r;
		case (st_r)
			AMDC_IDLE: begin
				if (cal_cmd && auto_sel) begin
					st_nxt  = AMDC_SETTLE;
					cnt_nxt = CNT_W'(SETTLE_CYC);
				end
			end
			AMDC_SETTLE: begin
				if (cnt_r == '0)
					st_nxt = AMDC_MEAS_REF;
				else
					cnt_nxt = cnt_r - CNT_W'(1);
			end
			AMDC_MEAS_REF: begin
				if (adc_done) begin
					ref_nxt = adc_value;
					st_nxt  = AMDC_CALC;
				end
			end
			AMDC_CALC: begin
				tgt_nxt   = quo[7:0];
				bit_nxt   = SEG_MSB;
				trial_nxt = SEG_MSB;
				st_nxt    = AMDC_TRY;
			end
			AMDC_TRY: st_nxt = AMDC_MEAS_TRY;
			// keep bit while amplitude stays at or above target
			// msb first, one measurement per bit
			AMDC_MEAS_TRY: begin
				if (adc_done) begin
					trial_nxt = (adc_value < tgt_r) ? (trial_r & ~bit_r)
						: trial_r;
					bit_nxt = bit_r >> 1;
					if (bit_r[0])
						st_nxt = AMDC_DONE;
					else begin
						trial_nxt = ((adc_value < tgt_r) ? (trial_r & ~bit_r)
							: trial_r) | (bit_r >> 1);
						st_nxt = AMDC_TRY;
					end
				end
			end
			AMDC_DONE: begin
				disp_nxt = trial_r;
				st_nxt   = AMDC_IDLE;
			end
			default: st_nxt = AMDC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r    <= AMDC_IDLE;
			ref_r   <= 8'h00;
			tgt_r   <= 8'h00;
			trial_r <= 8'h00;
			bit_r   <= 8'h00;
			disp_r  <= 8'h00;
			cnt_r   <= '0;
		end else begin
			st_r    <= st_nxt;
			ref_r   <= ref_nxt;
			tgt_r   <= tgt_nxt;
			trial_r <= trial_nxt;
			bit_r   <= bit_nxt;
			disp_r  <= disp_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// ==========================================================
	// Driver level outputs
	logic [7:0] drv_nxt, drv_r;
	logic [7:0] mod_lvl;
	logic       cal_act;

	assign cal_act  = (st_r != AMDC_IDLE);
	assign cal_busy = cal_act;
	assign tx_on    = cal_act;
	assign adc_start = (st_r == AMDC_SETTLE && cnt_r == '0) ||
		(st_r == AMDC_TRY);
	assign adc_result = ref_r;
	assign am_depth_display = disp_r;
	// select between calibrated and software level
	assign mod_lvl = am_depth_control[SEL_BIT] ? am_modulated_level : disp_r;

	always_comb begin
		drv_nxt = normal_level;
		if (st_r == AMDC_SETTLE || st_r == AMDC_MEAS_REF)
			drv_nxt = normal_level;
		else if (st_r == AMDC_TRY || st_r == AMDC_MEAS_TRY)
			drv_nxt = trial_r;
		// AM uses modulated level, OOK turns all segments off
		else if (modulate)
			drv_nxt = am_vs_ook_select ? mod_lvl : 8'hff;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			drv_r <= SEG_ALL_ON;
		else
			drv_r <= drv_nxt;
	end

	// both drivers share the segment setting
	assign antenna_driver_out_a = drv_r;
	assign antenna_driver_out_b = drv_r;

	// ==========================================================
	// Checks
	localparam int SETTLE_DLY = SETTLE_CYC + 1;
	logic [14:0] scaled_ref;
	logic [14:0] prod_lo;
	logic [14:0] prod_hi;

	// Quotient bounded by products, independent of the divider
	// Ratio field must hold still while busy; bounds use the live field
	assign scaled_ref = {1'b0, ref_r, {RATIO_W{1'b0}}};
	assign prod_lo    = {7'h00, tgt_r} * {8'h00, den};
	assign prod_hi    = prod_lo + {8'h00, den};

	sequence cal_start_s;
		st_r == AMDC_IDLE && cal_cmd && auto_sel;
	endsequence
	sequence meas_low_s;
		st_r == AMDC_MEAS_TRY && adc_done && adc_value < tgt_r;
	endsequence
	sequence meas_high_s;
		st_r == AMDC_MEAS_TRY && adc_done && adc_value >= tgt_r;
	endsequence

	manual_skip_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_IDLE && cal_cmd && !auto_sel |=> st_r == AMDC_IDLE)
		else $error("manual select started calibration");
	cal_start_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		cal_start_s |=> tx_on && st_r == AMDC_SETTLE)
		else $error("calibration did not start");
	// Reference must wait for the carrier to settle
	settle_len_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		cal_start_s |-> ##SETTLE_DLY adc_start)
		else $error("settle time wrong");
	ref_store_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_MEAS_REF && adc_done |=> adc_result == $past(adc_value))
		else $error("reference not stored");
	target_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_CALC && ratio == '0 |=> tgt_r == ref_r)
		else $error("zero ratio target wrong");
	target_bound_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_CALC |=> prod_lo <= scaled_ref && scaled_ref < prod_hi)
		else $error("target outside quotient bounds");
	first_bit_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_CALC |=> trial_r == SEG_MSB)
		else $error("approximation not msb first");
	// Too weak a field means too many segments off
	bit_drop_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		meas_low_s |=> (trial_r & $past(bit_r)) == 8'h00)
		else $error("trial bit kept below target");
	bit_keep_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		meas_high_s |=> (trial_r & $past(bit_r)) != 8'h00)
		else $error("trial bit dropped above target");
	disp_copy_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_DONE |=> am_depth_display == $past(trial_r))
		else $error("display not updated");
	drv_match_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		st_r == AMDC_MEAS_TRY |-> antenna_driver_out_a == trial_r &&
			antenna_driver_out_b == trial_r)
		else $error("drivers not at trial setting");
	am_level_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		!cal_act && modulate && am_vs_ook_select |=> drv_r == $past(mod_lvl))
		else $error("modulated level wrong");
	ook_level_a: assert property (@(posedge core_clk)
		disable iff (!rst_b)
		!cal_act && modulate && !am_vs_ook_select
			|=> antenna_driver_out_a == 8'hff)
		else $error("keyed level not all off");
endmodule // amdc_core
`default_nettype wire

// ===== hw/amdc_pkg.sv
// Constants and types for the Am_depth_control calibration block
package amdc_pkg;
	localparam int SEG_W       = 8;
	localparam int RATIO_W     = 6;
	localparam int SEL_BIT     = 7;
	localparam int RATIO_HI    = 6;
	localparam int RATIO_LO    = 1;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] NORM_RST   = 8'h00;
	localparam logic [7:0] SEG_ALL_ON = 8'h00;
	localparam logic [7:0] SEG_MSB    = 8'h80;
	localparam int SETTLE_NS   = 1000;
	localparam int CLK_NS      = 25;
	localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W       = 8;
	typedef enum logic [2:0] {
		AMDC_IDLE, AMDC_SETTLE, AMDC_MEAS_REF, AMDC_CALC,
		AMDC_TRY, AMDC_MEAS_TRY, AMDC_DONE
	} amdc_state_t;
endpackage

// ===== testbench/amdc_adc_model.sv
// Converter model answering measurement requests
`timescale 1ns/1ps
`default_nettype none
module amdc_adc_model (
	input  wire logic       core_clk,
	input  wire logic       adc_start,
	input  wire logic [7:0] drv,
	input  wire logic [3:0] lat,
	output logic            adc_done,
	output logic [7:0]      adc_value,
	output int              n_start
);
	// ==========
	// Answer after lat edges
	// Level falls as segments switch off; released bus shows inverse
	initial begin
		adc_done = 1'b0;
		adc_value = 8'h00;
		n_start = 0;
		forever begin
			@(posedge core_clk);
			if (adc_start === 1'b1) begin
				n_start++;
				repeat (lat) @(posedge core_clk);
				adc_done <= 1'b1;
				adc_value <= 8'hff - drv;
				@(posedge core_clk);
				adc_done <= 1'b0;
				adc_value <= ~adc_value;
			end
		end
	end
endmodule // amdc_adc_model
`default_nettype wire

// ===== testbench/amdc_core_test.sv
// Testbench for the depth calibration core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
	fail_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module amdc_core_test;
	import amdc_pkg::*;
	logic       core_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [7:0] ctrl = 8'h00;
	logic [7:0] norm = 8'h00;
	logic [7:0] modl = 8'h00;
	logic       am = 1'b1;
	logic       cal = 1'b0;
	logic       modu = 1'b0;
	logic [3:0] lat = 4'h2;
	logic       adc_start, adc_done, tx_on, cal_busy;
	logic [7:0] adc_value, adc_result, disp, drv_a, drv_b;
	int         n_start;
	int         fail_count = 0;
	int         n_compared = 0;
	always #12.5 core_clk = ~core_clk;
	amdc_core u_amdc_core (.core_clk(core_clk), .rst_b(rst_b),
		.am_depth_control(ctrl), .normal_level(norm),
		.am_modulated_level(modl), .am_vs_ook_select(am), .cal_cmd(cal),
		.modulate(modu), .adc_start(adc_start), .adc_done(adc_done),
		.adc_value(adc_value), .adc_result(adc_result),
		.am_depth_display(disp), .tx_on(tx_on),
		.antenna_driver_out_a(drv_a), .antenna_driver_out_b(drv_b),
		.cal_busy(cal_busy));
	amdc_adc_model u_amdc_adc_model (.core_clk(core_clk),
		.adc_start(adc_start), .drv(drv_a), .lat(lat),
		.adc_done(adc_done), .adc_value(adc_value), .n_start(n_start));
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 2000 && cal_busy !== 1'b0; i++) @(negedge core_clk);
		if (i == 2000) begin
			fail_count++;
			print_verdict();
		end
	endtask
	// ==========
	// Automatic calibration, second command refused while busy
	task automatic run_cal(input logic [5:0] r, input logic [3:0] l);
		logic [7:0] e;
		int k;
		e = 8'hff - 8'((255 * 64) / (64 + r));
		k = n_start;
		lat = l;
		@(negedge core_clk) ctrl = {1'b0, r, 1'b0};
		@(negedge core_clk) cal = 1'b1;
		@(negedge core_clk) cal = 1'b0;
		`CHK("busy", 1'b1, cal_busy)
		`CHK("tx_on", 1'b1, tx_on)
		@(negedge core_clk) cal = 1'b1;
		@(negedge core_clk) cal = 1'b0;
		wait_idle();
		`CHK("tx_off", 1'b0, tx_on)
		`CHK("adc_result", 8'hff, adc_result)
		`CHK("display", e, disp)
		`CHK("meas_count", 9, n_start - k)
		modu = 1'b1;
		repeat (3) @(negedge core_clk);
		`CHK("drv_a_mod", e, drv_a)
		`CHK("drv_b_mod", e, drv_b)
		modu = 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK("drv_a_norm", 8'h00, drv_a)
	endtask
	// ==========
	// Manual select, keying choice, raised normal level
	task automatic t_manual();
		logic [7:0] d;
		d = disp;
		ctrl = 8'h9c;
		modl = 8'h5a;
		@(negedge core_clk) cal = 1'b1;
		@(negedge core_clk) cal = 1'b0;
		`CHK("busy_man", 1'b0, cal_busy)
		modu = 1'b1;
		repeat (3) @(negedge core_clk);
		`CHK("drv_man", 8'h5a, drv_a)
		`CHK("disp_kept", d, disp)
		am = 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK("drv_ook", 8'hff, drv_b)
		modu = 1'b0;
		norm = 8'h0f;
		repeat (3) @(negedge core_clk);
		`CHK("drv_norm", 8'h0f, drv_a)
	endtask
	// ==========
	// external calibration for depths beyond the automatic range
	task automatic t_ext_cal();
		logic [7:0] best;
		logic [7:0] trial;
		logic [7:0] ref_amp;
		logic [7:0] tgt;
		int         b;
		am = 1'b1;
		ctrl = 8'h80;
		norm = 8'h00;
		repeat (2) @(negedge core_clk);
		ref_amp = 8'hff - drv_a;
		tgt = ref_amp >> 1;
		best = 8'h00;
		// msb-first search on the normal-level register
		for (b = 7; b >= 0; b--) begin
			trial = best | (8'h01 << b);
			@(negedge core_clk) norm = trial;
			repeat (2) @(negedge core_clk);
			`CHK("ext_try", trial, drv_a)
			if (8'hff - drv_a >= tgt)
				best = trial;
		end
		// result to modulated register, normal level restored
		modl = best;
		norm = 8'h00;
		modu = 1'b1;
		repeat (3) @(negedge core_clk);
		`CHK("ext_mod", 8'h80, drv_a)
		modu = 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK("ext_norm", 8'h00, drv_b)
	endtask
	initial begin
		// supplies up, no antenna tuning in this set-up
		repeat (6) @(negedge core_clk);
		rst_b = 1'b1;
		`CHK("drv_rst", 8'h00, drv_a)
		run_cal(6'h00, 4'h2);
		run_cal(6'h0e, 4'h7);
		run_cal(6'h3f, 4'h2);
		t_ext_cal();
		t_manual();
		print_verdict();
	end
endmodule // amdc_core_test
`default_nettype wire
